// *** logic/tws_pkg.sv ***
// constants for the three-wire serial port
`default_nettype none
package tws_pkg;
  localparam logic [15:0] MODE_ADDR = 16'hFF72;
  localparam logic [15:0] DATA_ADDR = 16'hFF73;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int EN_BIT = 7;
  localparam int RATE_HI_BIT = 5;
  localparam int RATE_LO_BIT = 4;
  localparam int ORDER_BIT = 2;
  localparam int SRC_BIT = 1;
  localparam logic [7:0] MODE_WMASK = 8'hB6;
  localparam logic [1:0] RATE_DIV4 = 2'h0;
  localparam logic [1:0] RATE_DIV8 = 2'h1;
  localparam int HALF_DIV4 = 2;
  localparam int HALF_DIV8 = 4;
  localparam int WORD_BITS = 8;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b10
  } tws_state_e;
endpackage : tws_pkg
`default_nettype wire

// *** logic/tws_edge.sv ***
// edge detector for the external shift clock pin
`default_nettype none
module tws_edge (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic din,
  output logic rise,
  output logic fall
);
  logic prev_r;
  logic prev_nxt;
  always_comb begin
    prev_nxt = din;
  end
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= prev_nxt;
    end
  end
  assign rise = din & ~prev_r;
  assign fall = ~din & prev_r;
endmodule : tws_edge
`default_nettype wire

// *** logic/tws_port.sv ***
// three-wire serial port: mode register, shift register and clocking
// How it works
// - disabled port is stopped, enabled does transfers
// - eight bit words over clock, out, in
// - each clock shifts one out, one in
// - order bit: 0 msb first, 1 lsb
// - source bit: 0 external pin, 1 internal
// - rate 00 divides by 4, 01 by 8
// - bit 7 enables the port
// - eight bit shift register, byte access only
// - shift register has no reset value
// - input pin is sampled on every transfer, never free as gpio
`default_nettype none
module tws_port (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE,
  input wire logic SI_IN,
  output logic SO_OUT,
  output logic SO_OE,
  output logic DONE_IRQ,
  output logic BUSY
);
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] shreg_r, shreg_nxt;
  logic [3:0] bits_r, bits_nxt;
  logic [2:0] div_r, div_nxt;
  logic sck_r, sck_nxt;
  logic so_r, so_nxt;
  logic in_bit_r, in_bit_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  tws_pkg::tws_state_e st_r, st_nxt;
  logic ext_rise, ext_fall;
  logic en, lsb, src_int, rate_ok, shift_ev, sample_ev;
  logic [2:0] half;

  tws_edge u_edge (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .din(SCK_IN),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  assign en = mode_r[tws_pkg::EN_BIT];
  assign lsb = mode_r[tws_pkg::ORDER_BIT];
  assign src_int = mode_r[tws_pkg::SRC_BIT];
  // prohibited rate codes leave the internal clock still
  assign rate_ok = (mode_r[5:4] == tws_pkg::RATE_DIV4) ||
    (mode_r[5:4] == tws_pkg::RATE_DIV8);
  assign half = (mode_r[5:4] == tws_pkg::RATE_DIV4) ? 3'(tws_pkg::HALF_DIV4) :
    3'(tws_pkg::HALF_DIV8);

  // internal clock state machine and edge events
  always_comb begin
    st_nxt = st_r;
    div_nxt = div_r;
    sck_nxt = 1'b1;
    shift_ev = 1'b0;
    sample_ev = 1'b0;
    if (!en || bits_r == 4'h0) begin
      st_nxt = tws_pkg::ST_IDLE;
      div_nxt = 3'h0;
    end else if (src_int) begin
      sck_nxt = sck_r;
      case (st_r)
        tws_pkg::ST_IDLE: begin
          if (rate_ok) begin
            st_nxt = tws_pkg::ST_LOW;
            sck_nxt = 1'b0;
            shift_ev = bits_r != 4'(tws_pkg::WORD_BITS);
            div_nxt = 3'h1;
          end
        end
        tws_pkg::ST_LOW: begin
          if (div_r == half) begin
            st_nxt = tws_pkg::ST_HIGH;
            sck_nxt = 1'b1;
            sample_ev = 1'b1;
            div_nxt = 3'h1;
          end else begin
            div_nxt = div_r + 3'h1;
          end
        end
        tws_pkg::ST_HIGH: begin
          // idle state supplies the last high cycle, so the period is two halves
          if (div_r == half - 3'h1) begin
            st_nxt = tws_pkg::ST_IDLE;
            div_nxt = 3'h0;
          end else begin
            div_nxt = div_r + 3'h1;
          end
        end
        default: begin
          st_nxt = tws_pkg::ST_IDLE;
        end
      endcase
    end else begin
      shift_ev = ext_fall && bits_r != 4'(tws_pkg::WORD_BITS);
      sample_ev = ext_rise;
    end
  end

  // registers, shifting and completion
  always_comb begin
    mode_nxt = mode_r;
    shreg_nxt = shreg_r;
    bits_nxt = bits_r;
    so_nxt = so_r;
    in_bit_nxt = in_bit_r;
    irq_nxt = 1'b0;
    rdata_nxt = 8'h00;
    if (RD) begin
      if (ADDR == tws_pkg::MODE_ADDR) begin
        rdata_nxt = mode_r;
      end else if (ADDR == tws_pkg::DATA_ADDR) begin
        rdata_nxt = shreg_r;
      end
    end
    if (shift_ev) begin
      so_nxt = lsb ? shreg_r[0] : shreg_r[7];
    end
    if (sample_ev && bits_r != 4'h0) begin
      shreg_nxt = lsb ? {SI_IN, shreg_r[7:1]} : {shreg_r[6:0], SI_IN};
      bits_nxt = bits_r - 4'h1;
      // output moves on the data write and then only on falling edges, so the far side samples a settled bit
      if (bits_r == 4'h1) begin
        irq_nxt = 1'b1;
      end
    end
    if (!en) begin
      bits_nxt = 4'h0;
    end
    if (WR && ADDR == tws_pkg::MODE_ADDR) begin
      mode_nxt = WDATA & tws_pkg::MODE_WMASK;
    end else if (WR && ADDR == tws_pkg::DATA_ADDR) begin
      shreg_nxt = WDATA;
      if (en) begin
        bits_nxt = 4'(tws_pkg::WORD_BITS);
        so_nxt = lsb ? WDATA[0] : WDATA[7];
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_r <= tws_pkg::MODE_RESET;
      bits_r <= 4'h0;
      div_r <= 3'h0;
      sck_r <= 1'b1;
      so_r <= 1'b0;
      in_bit_r <= 1'b0;
      irq_r <= 1'b0;
      rdata_r <= 8'h00;
      st_r <= tws_pkg::ST_IDLE;
    end else begin
      mode_r <= mode_nxt;
      bits_r <= bits_nxt;
      div_r <= div_nxt;
      sck_r <= sck_nxt;
      so_r <= so_nxt;
      in_bit_r <= in_bit_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
      st_r <= st_nxt;
    end
  end

  // shift register is left without reset
  always_ff @(posedge MCLK) begin
    shreg_r <= shreg_nxt;
  end

  assign RDATA = rdata_r;
  assign SCK_OUT = sck_r;
  assign SCK_OE = en & src_int;
  assign SO_OUT = so_r;
  assign SO_OE = en;
  assign DONE_IRQ = irq_r;
  assign BUSY = bits_r != 4'h0;
endmodule : tws_port
`default_nettype wire

// *** bench/tws_port_monitor.sv ***
// assertions on the serial port pins
`default_nettype none
module tws_port_monitor (
  input wire logic MCLK, RST_N, WR, RD, SCK_OUT, SCK_OE, SO_OE, DONE_IRQ, BUSY,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] RDATA
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_fin; ##[28:72] DONE_IRQ ##1 !BUSY; endsequence
  property p_unm; RD && ADDR[15:1] != 15'h7FB9 |=> RDATA == 8'h00; endproperty
  property p_rdz; !$past(RD) |-> RDATA == 8'h00; endproperty
  property p_idle; !BUSY |-> SCK_OUT; endproperty
  property p_stop; !SO_OE |-> !BUSY && !SCK_OE; endproperty
  property p_go; WR && ADDR == 16'hFF73 && SO_OE && !BUSY |=> BUSY; endproperty
  property p_half; $changed(SCK_OUT) |=> $stable(SCK_OUT); endproperty
  property p_pul; DONE_IRQ |=> !DONE_IRQ; endproperty
  property p_xfer; $rose(BUSY) && SCK_OE |-> s_fin; endproperty
  a_unm: assert property (p_unm) else $error("unmapped");
  a_rdz: assert property (p_rdz) else $error("rdata");
  a_idle: assert property (p_idle) else $error("idle");
  a_stop: assert property (p_stop) else $error("stop");
  a_go: assert property (p_go) else $error("start");
  a_half: assert property (p_half) else $error("half");
  a_pul: assert property (p_pul) else $error("pulse");
  a_xfer: assert property (p_xfer) else $error("length");
endmodule : tws_port_monitor
`default_nettype wire

// *** bench/tws_peer.sv ***
// serial peripheral on the far side of the port
`default_nettype none
module tws_peer (
  input wire logic sck, so, ld,
  input wire logic [7:0] v,
  output logic si,
  output logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] s;
  logic r;
  logic first;
  always @(posedge sck) r <= so;
  // the first falling edge launches the loaded msb, so it must not shift
  always @(posedge sck or posedge ld)
    if (ld) first <= 1'b1;
    else first <= 1'b0;
  always @(negedge sck or posedge ld)
    if (ld) s <= v;
    else if (!first) s <= {s[6:0], r};
  assign si = s[7];
  assign rx = {s[6:0], r};
endmodule : tws_peer
`default_nettype wire

// *** bench/tws_port_tb.sv ***
// testbench for the serial port
`default_nettype none
module tws_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK = 0, RST_N = 0, WR = 0, RD = 0, sck_tb = 1, ld = 0;
  logic [15:0] ADDR = 0;
  logic [7:0] WDATA = 0, RDATA, v, rx, q, d, m;
  logic SCK_OUT, SCK_OE, SO_OUT, SO_OE, DONE_IRQ, BUSY, sck, si;
  int err_total = 0, cmp_count = 0, k, t;
  assign sck = SCK_OE ? SCK_OUT : sck_tb;
  always #10 MCLK = ~MCLK;
  tws_port dut (.MCLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .SCK_IN(sck_tb),
    .SCK_OUT, .SCK_OE, .SI_IN(si), .SO_OUT, .SO_OE, .DONE_IRQ, .BUSY);
  tws_peer peer (.sck, .so(SO_OUT), .ld, .v, .si, .rx);
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [15:0] a, logic [7:0] x);
    @(negedge MCLK) {ADDR, WDATA, WR} = {a, x, 1'b1};
    @(negedge MCLK) WR = 0;
  endtask : wr
  task automatic rd(logic [15:0] a);
    @(negedge MCLK) {ADDR, RD} = {a, 1'b1};
    @(negedge MCLK) RD = 0;
    q = RDATA;
  endtask : rd
  function automatic logic [7:0] rev(logic [7:0] x);
    return {<<{x}};
  endfunction : rev
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  initial begin
    void'($urandom(32'h01aedf26));
    repeat (5) @(negedge MCLK);
    RST_N = 1;
    rd(16'hFF72);
    chk("mode", 8'h00, q);
    rd(16'h1234);
    chk("unmapped", 8'h00, q);
    wr(16'hFF73, 8'hA5);
    rd(16'hFF73);
    chk("stored", 8'hA5, q);
    for (int i = 0; i < 8; i++) begin
      m = {1'b1, 2'b0, i[0], 1'b0, i[1], ~i[2], 1'b0};
      d = $urandom;
      v = $urandom;
      wr(16'hFF72, 8'h00);
      wr(16'hFF72, m);
      rd(16'hFF72);
      chk("mode", m, q);
      @(negedge MCLK) ld = 1;
      @(negedge MCLK) ld = 0;
      wr(16'hFF73, d);
      t = 0;
      for (k = 0; k < 200; k++) begin
        @(negedge MCLK);
        if (DONE_IRQ) break;
        if (!m[1] && t < 16 && k % 4 == 3) begin
          sck_tb = ~sck_tb;
          t++;
        end
      end
      if (k == 200) begin
        chk("done", 8'h01, 8'h00);
        final_report();
      end
      rd(16'hFF73);
      chk("rx", i[1] ? rev(v) : v, q);
      chk("tx", i[1] ? rev(d) : d, rx);
      $display("test %0d done", i);
    end
    final_report();
  end
endmodule : tws_port_tb
bind tws_port tws_port_monitor mon (.MCLK, .RST_N, .WR, .RD, .SCK_OUT, .SCK_OE,
  .SO_OE, .DONE_IRQ, .BUSY, .ADDR, .RDATA);
`default_nettype wire
